// ### bench/tb_top.sv
// Self-checking bench for the flash protection, status and command sequencer
`include "nvmps_cfg.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // APB
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // System
  logic [7:0] stored_protection_byte = 8'hBF;
  logic stop_req = 1'b0;
  logic array_erased = 1'b0;
  logic irq;
  logic [1:0] security_state_code;

  int num_errors = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic se;
  logic [15:0] addrs [4] = '{16'hF9FF, 16'hFA00, 16'h17FF, 16'h17DF};
  logic [31:0] viol [4] = '{32'h00, 32'h20, 32'h20, 32'h00};
  logic [7:0] codes [6] = '{`NVMPS_CMD_BLANK, `NVMPS_CMD_BYTE, `NVMPS_CMD_BURST,
                            `NVMPS_CMD_SECT, `NVMPS_CMD_MASS, `NVMPS_CMD_ABORT};
  logic [7:0] prot_w [3] = '{8'hFF, 8'h7E, 8'hBD};
  logic [7:0] prot_e [3] = '{8'hBF, 8'h7E, 8'h7E};

  // Long enough that a status read can land while a command still runs
  nvmps_top #(.OP_CYCLES(24)) nvmps_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stored_protection_byte(stored_protection_byte), .stop_req(stop_req),
    .array_erased(array_erased), .irq(irq), .security_state_code(security_state_code)
  );

  always #10 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // Holds the request until pready is seen high, then takes data and releases
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("BAD %0t no pready", $time);
      wrap_up();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic go(input logic [15:0] a, input logic [7:0] c);
    apb(1'b1, `NVMPS_OFF_ADDR, {16'h0000, a});
    apb(1'b1, `NVMPS_OFF_DATA, 32'h0000_005A);
    apb(1'b1, `NVMPS_OFF_CMD, {24'h000000, c});
    apb(1'b1, `NVMPS_OFF_STAT, 32'h0000_0080);
  endtask : go

  task automatic wait_done;
    int n;
    n = 0;
    do begin
      apb(1'b0, `NVMPS_OFF_STAT, 32'h0);
      n++;
    end while (rd[6] !== 1'b1 && n < 40);
    if (rd[6] !== 1'b1) begin
      num_errors++;
      $display("BAD %0t command never completed", $time);
      wrap_up();
    end
  endtask : wait_done

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, `NVMPS_OFF_STAT, 32'h0);
    chk(rd, 32'h0000_00C0, "status after reset");
    apb(1'b0, `NVMPS_OFF_PROT, 32'h0);
    chk(rd, 32'h0000_00BF, "protection load");
    chk({30'h0, security_state_code}, 32'h3, "secure at reset");
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `NVMPS_OFF_PROT, {24'h0, prot_w[i]});
      apb(1'b0, `NVMPS_OFF_PROT, 32'h0);
      chk(rd, {24'h0, prot_e[i]}, "protection write");
    end
    // Program before the divider is set
    go(16'hF9FF, `NVMPS_CMD_BYTE);
    wait_done();
    chk(rd & 32'h30, 32'h10, "no divider");
    apb(1'b1, `NVMPS_OFF_STAT, 32'h10);
    apb(1'b0, `NVMPS_OFF_STAT, 32'h0);
    chk(rd & 32'h10, 32'h0, "access error cleared on 1");
    // Command written before its data breaks the sequence
    apb(1'b1, `NVMPS_OFF_CMD, 32'h20);
    apb(1'b0, `NVMPS_OFF_STAT, 32'h0);
    chk(rd & 32'h10, 32'h10, "command before data");
    apb(1'b1, `NVMPS_OFF_STAT, 32'h10);
    apb(1'b1, `NVMPS_OFF_DIV, 32'h13);
    apb(1'b1, `NVMPS_OFF_IRQ_EN, 32'h7);
    // Region boundaries; a written 0 must not clear a flag
    for (int i = 0; i < 4; i++) begin
      go(addrs[i], `NVMPS_CMD_BYTE);
      wait_done();
      chk(rd & 32'h30, viol[i], "region");
      apb(1'b1, `NVMPS_OFF_STAT, 32'h0);
      apb(1'b0, `NVMPS_OFF_STAT, 32'h0);
      chk(rd & 32'h30, viol[i], "flag kept on 0");
      apb(1'b1, `NVMPS_OFF_STAT, 32'h30);
      apb(1'b0, `NVMPS_OFF_STAT, 32'h0);
      chk(rd & 32'h30, 32'h0, "flag cleared on 1");
    end
    chk({31'h0, irq}, 32'h1, "irq raised");
    apb(1'b1, `NVMPS_OFF_IRQ_CLR, 32'h7);
    apb(1'b0, `NVMPS_OFF_IRQ_ST, 32'h0);
    chk(rd, 32'h0, "irq status cleared");
    chk({31'h0, irq}, 32'h0, "irq dropped");
    // Every command code; mass erase refused while anything is protected
    for (int i = 0; i < 6; i++) begin
      go(16'h1000, codes[i]);
      wait_done();
      chk(rd & 32'h20, (codes[i] == `NVMPS_CMD_MASS) ? 32'h20 : 32'h0, "code");
      apb(1'b1, `NVMPS_OFF_STAT, 32'h30);
    end
    go(16'h1000, 8'h33);
    wait_done();
    chk(rd & 32'h10, 32'h10, "illegal code");
    apb(1'b1, `NVMPS_OFF_STAT, 32'h30);
    // Flags while a command runs; a non-burst launch behind it is refused
    go(16'h1000, `NVMPS_CMD_BYTE);
    apb(1'b0, `NVMPS_OFF_STAT, 32'h0);
    chk(rd & 32'hC0, 32'h80, "busy flags");
    go(16'h1000, `NVMPS_CMD_SECT);
    wait_done();
    chk(rd & 32'hF4, 32'hD0, "idle flags after refused queue");
    apb(1'b1, `NVMPS_OFF_STAT, 32'h30);
    // A burst queues behind a running burst and fills the buffer
    go(16'h1000, `NVMPS_CMD_BURST);
    go(16'h1010, `NVMPS_CMD_BURST);
    apb(1'b0, `NVMPS_OFF_STAT, 32'h0);
    chk(rd & 32'hC0, 32'h0, "burst queued");
    wait_done();
    chk(rd & 32'h30, 32'h0, "burst pair done");
    // Passing blank check
    array_erased <= 1'b1;
    go(16'h1000, `NVMPS_CMD_BLANK);
    wait_done();
    chk(rd & 32'h04, 32'h04, "blank set");
    chk({30'h0, security_state_code}, 32'h2, "unsecured");
    apb(1'b1, `NVMPS_OFF_STAT, 32'h04);
    apb(1'b0, `NVMPS_OFF_STAT, 32'h0);
    chk(rd & 32'h04, 32'h04, "blank ignores write");
    go(16'h1000, `NVMPS_CMD_BYTE);
    wait_done();
    chk(rd & 32'h04, 32'h00, "blank cleared by launch");
    // Stop mode in mid-command
    go(16'h1000, `NVMPS_CMD_BYTE);
    stop_req <= 1'b1;
    wait_done();
    chk(rd & 32'h10, 32'h10, "stop while busy");
    stop_req <= 1'b0;
    apb(1'b1, `NVMPS_OFF_STAT, 32'h30);
    // Unmapped address
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, se}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    wrap_up();
  end
endmodule : tb_top

// ### include/nvmps_cfg.svh
// Register offsets, field positions, reset values and timing counts
`ifndef NVMPS_CFG_SVH
`define NVMPS_CFG_SVH

`define NVMPS_OFF_PROT     12'h000
`define NVMPS_OFF_STAT     12'h004
`define NVMPS_OFF_CMD      12'h008
`define NVMPS_OFF_DIV      12'h00C
`define NVMPS_OFF_ADDR     12'h010
`define NVMPS_OFF_DATA     12'h014
`define NVMPS_OFF_SEC      12'h018
`define NVMPS_OFF_IRQ_ST   12'h01C
`define NVMPS_OFF_IRQ_CLR  12'h020
`define NVMPS_OFF_IRQ_EN   12'h024
`define NVMPS_OFF_CTRL     12'h028

`define NVMPS_BIT_CBEF     7
`define NVMPS_BIT_CCF      6
`define NVMPS_BIT_PVIOL    5
`define NVMPS_BIT_ACCERR   4
`define NVMPS_BIT_BLANK    2

`define NVMPS_EPS_HI       7
`define NVMPS_EPS_LO       6
`define NVMPS_FPS_HI       5
`define NVMPS_FPS_LO       0
`define NVMPS_EPS_NONE     2'h3
`define NVMPS_FPS_NONE     6'h3F
`define NVMPS_FPS_ALL      6'h18
`define NVMPS_EE_TOP       16'h17FF
`define NVMPS_EE_BASE      16'h17C0
`define NVMPS_FL_STEP      16'h0600

`define NVMPS_CMD_BLANK    8'h05
`define NVMPS_CMD_BYTE     8'h20
`define NVMPS_CMD_BURST    8'h25
`define NVMPS_CMD_SECT     8'h40
`define NVMPS_CMD_MASS     8'h41
`define NVMPS_CMD_ABORT    8'h47

`define NVMPS_SEC_RESET    2'h3
`define NVMPS_SEC_OPEN     2'h2

`define NVMPS_IRQ_CCF      0
`define NVMPS_IRQ_PVIOL    1
`define NVMPS_IRQ_ACCERR   2
`define NVMPS_IRQ_W        3

`define NVMPS_OP_CYCLES    8

`endif

// ### include/nvmps_guard_if.sv
// Protection query bundle between the sequencer and the guard checker
interface nvmps_guard_if;
  logic [7:0] prot;
  logic [15:0] addr;
  logic hit;
  logic any;

  modport seq (output prot, output addr, input hit, input any);
  modport chk (input prot, input addr, output hit, output any);
endinterface : nvmps_guard_if

// ### include/nvmps_pkg.sv
// Types shared by the flash sequencer files
package nvmps_pkg;
  typedef enum logic [2:0] {
    NVMPS_OP_NONE,
    NVMPS_OP_BLANK,
    NVMPS_OP_BYTE,
    NVMPS_OP_BURST,
    NVMPS_OP_SECT,
    NVMPS_OP_MASS,
    NVMPS_OP_ABORT
  } nvmps_op_t;

  typedef enum {
    NVMPS_IDLE,
    NVMPS_BUSY
  } nvmps_state_t;
endpackage : nvmps_pkg

// ### rtl/nvmps_guard.sv
// Combinational protected-region checker for flash and EEPROM
`include "nvmps_cfg.svh"

module nvmps_guard
  import nvmps_pkg::*;
(
  nvmps_guard_if.chk g
);
  logic [1:0] eeprom_guard_select;
  logic [5:0] array_guard_select;
  logic [16:0] fl_len;
  logic [16:0] fl_base;
  logic [15:0] ee_base;
  logic ee_hit;
  logic fl_hit;

  assign eeprom_guard_select = g.prot[`NVMPS_EPS_HI:`NVMPS_EPS_LO];
  assign array_guard_select = g.prot[`NVMPS_FPS_HI:`NVMPS_FPS_LO];

  // EEPROM region grows by doubling from the top of the EEPROM window
  // Byte counts span both pages; only the visible window is compared
  always_comb begin
    case (eeprom_guard_select) // see [R1]
      2'h2: ee_base = `NVMPS_EE_TOP - 16'h000F;
      2'h1: ee_base = `NVMPS_EE_TOP - 16'h001F;
      2'h0: ee_base = `NVMPS_EE_BASE;
      default: ee_base = 16'h0000;
    endcase
  end
  assign ee_hit = (eeprom_guard_select != `NVMPS_EPS_NONE) && (g.addr >= ee_base) &&
                  (g.addr <= `NVMPS_EE_TOP);

  // Each code step below 0x3F adds two sectors below 0xFFFF
  assign fl_len = 17'(6'(`NVMPS_FPS_NONE - array_guard_select)) * 17'(`NVMPS_FL_STEP); // see [R2]
  assign fl_base = 17'h10000 - fl_len;
  assign fl_hit = (array_guard_select != `NVMPS_FPS_NONE) &&
                  ((array_guard_select <= `NVMPS_FPS_ALL) || ({1'b0, g.addr} >= fl_base)); // see [R2]

  assign g.hit = ee_hit || fl_hit;
  assign g.any = (eeprom_guard_select != `NVMPS_EPS_NONE) || (array_guard_select != `NVMPS_FPS_NONE);
endmodule : nvmps_guard

// ### rtl/nvmps_top.sv
// Flash and EEPROM protection, status and command sequencer with APB slave
`include "nvmps_cfg.svh"

// Functional notes
// [R1] Protection bits 7:6 pick EEPROM top region: none, 32, 64 or 128 bytes.
// [R2] Protection bits 5:0 pick flash region growing down by 0x600; low codes protect all.
// [R3] Writing 1 to status bit 7 launches; bit reads 0 while buffer full.
// [R4] Only burst program may queue behind a running command; code queues it only behind a running burst.
// [R5] Status bit 6 set when idle and buffer empty; cleared on launch; read-only.
// [R6] Program or erase into protected region sets bit 5 and drops command.
// [R7] Protection violation flag clears only on written 1.
// [R8] Bad sequence, no divider written, or stop while busy set bit 4; code checks the divider only on program and erase launches.
// [R9] Access error flag clears only on written 1.
// [R10] Blank check passing sets bit 2; cleared on next valid launch.
// [R11] Command codes 05, 20, 25, 40, 41, 47 are decoded.
// [R12] Any other code is illegal: access error, not executed.
// [R13] Protection writes accepted only when they enlarge the region.
// [R14] Mass erase with anything protected is a protection violation.
// [R15] Successful blank check sets security code to unsecured 1:0.
// [R16] Software writes data, then command, then launches when ready and error-free.
// [R17] Protection loads from its stored byte during every reset; code holds 00 in reset, loads on three clocks after release.
module nvmps_top
  import nvmps_pkg::*;
#(
  parameter int OP_CYCLES = `NVMPS_OP_CYCLES
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System
  input wire logic [7:0] stored_protection_byte,
  input wire logic stop_req,
  input wire logic array_erased,
  // Status
  output logic irq,
  output logic [1:0] security_state_code
);
  nvmps_guard_if gi ();
  nvmps_guard u_guard (.g(gi));

  logic [7:0] nvm_protection;
  logic [7:0] nvm_command;
  logic [15:0] tgt_addr;
  logic [7:0] tgt_data;
  logic div_written;
  logic cmd_buffer_empty_flag;
  logic cmd_complete_flag;
  logic guard_violation_flag;
  logic sequence_error_flag;
  logic erased_verified_flag;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  logic [7:0] nvm_clock_divider;
  logic stage_addr;
  logic stage_cmd;
  nvmps_state_t state;
  nvmps_op_t cur_op;
  nvmps_op_t buf_op;
  logic buf_full;
  logic [15:0] cnt;
  logic [1:0] prot_load;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic wr;
  logic rd_access;
  logic mapped;
  logic launch;
  logic [7:0] st_byte;
  logic bad_seq;

  function automatic nvmps_op_t decode_cmd(input logic [7:0] c);
    case (c) // see [R11]
      `NVMPS_CMD_BLANK: decode_cmd = NVMPS_OP_BLANK;
      `NVMPS_CMD_BYTE: decode_cmd = NVMPS_OP_BYTE;
      `NVMPS_CMD_BURST: decode_cmd = NVMPS_OP_BURST;
      `NVMPS_CMD_SECT: decode_cmd = NVMPS_OP_SECT;
      `NVMPS_CMD_MASS: decode_cmd = NVMPS_OP_MASS;
      `NVMPS_CMD_ABORT: decode_cmd = NVMPS_OP_ABORT;
      default: decode_cmd = NVMPS_OP_NONE;
    endcase
  endfunction : decode_cmd

  function automatic logic is_mapped(input logic [11:0] a);
    case (a)
      `NVMPS_OFF_PROT, `NVMPS_OFF_STAT, `NVMPS_OFF_CMD, `NVMPS_OFF_DIV,
      `NVMPS_OFF_ADDR, `NVMPS_OFF_DATA, `NVMPS_OFF_SEC, `NVMPS_OFF_IRQ_ST,
      `NVMPS_OFF_IRQ_CLR, `NVMPS_OFF_IRQ_EN, `NVMPS_OFF_CTRL: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // Single-wait-state slave: pready rises on the second access cycle
  assign rd_access = psel && penable && !pready;
  assign mapped = is_mapped(paddr);
  assign wr = rd_access && pwrite && mapped;
  assign launch = wr && (paddr == `NVMPS_OFF_STAT) && pwdata[`NVMPS_BIT_CBEF] &&
                  cmd_buffer_empty_flag; // see [R3]

  assign st_byte = {cmd_buffer_empty_flag, cmd_complete_flag, guard_violation_flag,
                    sequence_error_flag, 1'b0, erased_verified_flag, 2'b00};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= rd_access;
      pslverr <= rd_access && !mapped;
      if (rd_access && !pwrite) begin
        case (paddr)
          `NVMPS_OFF_PROT: prdata <= {24'h000000, nvm_protection};
          `NVMPS_OFF_STAT: prdata <= {24'h000000, st_byte};
          `NVMPS_OFF_CMD: prdata <= {24'h000000, nvm_command};
          `NVMPS_OFF_DIV: prdata <= {24'h000000, nvm_clock_divider};
          `NVMPS_OFF_ADDR: prdata <= {16'h0000, tgt_addr};
          `NVMPS_OFF_DATA: prdata <= {24'h000000, tgt_data};
          `NVMPS_OFF_SEC: prdata <= {30'h0, security_state_code};
          `NVMPS_OFF_IRQ_ST: prdata <= {29'h0, irq_status};
          `NVMPS_OFF_IRQ_EN: prdata <= {29'h0, irq_enable};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Protection register

  logic prot_enlarges;
  assign prot_enlarges = (pwdata[`NVMPS_EPS_HI:`NVMPS_EPS_LO] <=
                          nvm_protection[`NVMPS_EPS_HI:`NVMPS_EPS_LO]) &&
                         (pwdata[`NVMPS_FPS_HI:`NVMPS_FPS_LO] <=
                          nvm_protection[`NVMPS_FPS_HI:`NVMPS_FPS_LO]);

  // The stored byte is a port, so it is caught by each of the three clocks after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_protection <= 8'h00;
      prot_load <= 2'h0;
    end else if (prot_load != 2'h3) begin
      nvm_protection <= stored_protection_byte; // see [R17]
      prot_load <= prot_load + 2'h1;
    end else if (wr && paddr == `NVMPS_OFF_PROT && prot_enlarges) begin
      nvm_protection <= pwdata[7:0]; // see [R13]
    end
  end

  assign gi.prot = nvm_protection;
  assign gi.addr = tgt_addr;

  ////////////////////////////////////////////////////////////////////////
  // Staging registers: address/data, command, divider

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgt_addr <= 16'h0000;
      tgt_data <= 8'h00;
      nvm_command <= 8'h00;
      nvm_clock_divider <= 8'h00;
      div_written <= 1'b0;
      stage_addr <= 1'b0;
      stage_cmd <= 1'b0;
    end else begin
      if (wr && paddr == `NVMPS_OFF_DIV && !div_written) begin
        nvm_clock_divider <= pwdata[7:0];
        div_written <= 1'b1;
      end
      if (launch || bad_seq) begin
        stage_addr <= 1'b0;
        stage_cmd <= 1'b0;
      end else if (wr && paddr == `NVMPS_OFF_DATA && cmd_buffer_empty_flag) begin
        tgt_data <= pwdata[7:0];
        stage_addr <= 1'b1;
      end else if (wr && paddr == `NVMPS_OFF_ADDR && cmd_buffer_empty_flag) begin
        tgt_addr <= pwdata[15:0];
      end else if (wr && paddr == `NVMPS_OFF_CMD && stage_addr) begin
        nvm_command <= pwdata[7:0];
        stage_cmd <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Launch checks

  nvmps_op_t new_op;
  logic is_pgm_erase;
  logic launch_acc;
  logic launch_prot;
  logic launch_ok;
  logic stop_abort;

  // Command write before data, or launch without a full sequence, is an error
  assign bad_seq = wr && ((paddr == `NVMPS_OFF_CMD && !stage_addr) ||
                   (paddr == `NVMPS_OFF_STAT && pwdata[`NVMPS_BIT_CBEF] &&
                    cmd_buffer_empty_flag && !stage_cmd)); // see [R8]
  assign new_op = decode_cmd(nvm_command);
  assign is_pgm_erase = (new_op == NVMPS_OP_BYTE) || (new_op == NVMPS_OP_BURST) ||
                        (new_op == NVMPS_OP_SECT) || (new_op == NVMPS_OP_MASS);
  assign launch_acc = launch && (!stage_cmd || new_op == NVMPS_OP_NONE || // see [R12]
                      (is_pgm_erase && !div_written) || // see [R8]
                      (state == NVMPS_BUSY &&
                       !(new_op == NVMPS_OP_BURST && cur_op == NVMPS_OP_BURST))); // see [R4]
  assign launch_prot = launch && !launch_acc &&
                       (((new_op == NVMPS_OP_MASS) && gi.any) || // see [R14]
                        (is_pgm_erase && new_op != NVMPS_OP_MASS && gi.hit)); // see [R6]
  assign launch_ok = launch && !launch_acc && !launch_prot;
  assign stop_abort = stop_req && state == NVMPS_BUSY; // see [R8]

  ////////////////////////////////////////////////////////////////////////
  // Execution engine with one-deep burst buffer

  logic op_done;
  assign op_done = state == NVMPS_BUSY && cnt == 16'(OP_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= NVMPS_IDLE;
      cur_op <= NVMPS_OP_NONE;
      buf_op <= NVMPS_OP_NONE;
      buf_full <= 1'b0;
      cnt <= 16'h0000;
    end else begin
      case (state)
        NVMPS_IDLE: begin
          cnt <= 16'h0000;
          if (launch_ok) begin
            state <= NVMPS_BUSY;
            cur_op <= new_op;
          end
        end
        NVMPS_BUSY: begin
          cnt <= cnt + 16'h0001;
          if (stop_abort) begin
            state <= NVMPS_IDLE;
            buf_full <= 1'b0;
          end else if (launch_ok && op_done) begin
            // A burst launched on the last cycle starts at once, else the finish is lost
            cur_op <= new_op; // see [R4]
            cnt <= 16'h0000;
          end else if (launch_ok) begin
            buf_op <= new_op; // see [R4]
            buf_full <= 1'b1;
          end else if (op_done && buf_full) begin
            cur_op <= buf_op; // see [R3]
            buf_full <= 1'b0;
            cnt <= 16'h0000;
          end else if (op_done) begin
            state <= NVMPS_IDLE;
          end
        end
        default: state <= NVMPS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags

  logic blank_pass;
  assign blank_pass = op_done && cur_op == NVMPS_OP_BLANK && array_erased;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_buffer_empty_flag <= 1'b1;
      cmd_complete_flag <= 1'b1;
    end else begin
      // Buffer frees when it hands its command on, or a launch is refused
      if (launch) begin
        cmd_buffer_empty_flag <= 1'b0; // see [R3]
      end else if (!cmd_buffer_empty_flag && (!buf_full || op_done || stop_abort)) begin
        cmd_buffer_empty_flag <= 1'b1; // see [R3]
      end
      if (launch_ok) begin
        cmd_complete_flag <= 1'b0; // see [R5]
      end else if (state == NVMPS_IDLE && cmd_buffer_empty_flag && !launch) begin
        cmd_complete_flag <= 1'b1; // see [R5]
      end
    end
  end

  // Hardware set takes priority over a same-cycle software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_violation_flag <= 1'b0;
      sequence_error_flag <= 1'b0;
    end else begin
      if (launch_prot) begin
        guard_violation_flag <= 1'b1; // see [R6]
      end else if (wr && paddr == `NVMPS_OFF_STAT && pwdata[`NVMPS_BIT_PVIOL]) begin
        guard_violation_flag <= 1'b0; // see [R7]
      end
      if (launch_acc || bad_seq || stop_abort) begin
        sequence_error_flag <= 1'b1; // see [R8]
      end else if (wr && paddr == `NVMPS_OFF_STAT && pwdata[`NVMPS_BIT_ACCERR]) begin
        sequence_error_flag <= 1'b0; // see [R9]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erased_verified_flag <= 1'b0;
      security_state_code <= `NVMPS_SEC_RESET;
    end else begin
      if (blank_pass) begin
        erased_verified_flag <= 1'b1; // see [R10]
        security_state_code <= `NVMPS_SEC_OPEN; // see [R15]
      end else if (launch_ok) begin
        erased_verified_flag <= 1'b0; // see [R10]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic [2:0] irq_set;
  assign irq_set = {launch_acc || bad_seq || stop_abort, launch_prot,
                    op_done && !buf_full};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 3'h0;
      irq_enable <= 3'h0;
      irq <= 1'b0;
    end else begin
      if (wr && paddr == `NVMPS_OFF_IRQ_EN) begin
        irq_enable <= pwdata[2:0];
      end
      if (wr && paddr == `NVMPS_OFF_IRQ_CLR) begin
        irq_status <= (irq_status & ~pwdata[2:0]) | irq_set;
      end else begin
        irq_status <= irq_status | irq_set;
      end
      irq <= |(irq_status & irq_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  a_prot_no_shrink: assert property (@(posedge pclk) disable iff (!presetn) // see [R13]
    (prot_load == 2'h3 && $past(prot_load) == 2'h3) |->
      (nvm_protection[7:6] <= $past(nvm_protection[7:6]) &&
       nvm_protection[5:0] <= $past(nvm_protection[5:0])))
    else $error("protection region shrank");
  a_launch_clears_cbef: assert property (@(posedge pclk) disable iff (!presetn) // see [R3]
    launch |=> !cmd_buffer_empty_flag)
    else $error("launch did not fill buffer");
  a_ccf_clear: assert property (@(posedge pclk) disable iff (!presetn) // see [R5]
    launch_ok |=> !cmd_complete_flag)
    else $error("complete flag stayed set after launch");
  a_ccf_idle: assert property (@(posedge pclk) disable iff (!presetn) // see [R5]
    cmd_complete_flag |-> state == NVMPS_IDLE || $past(state) == NVMPS_IDLE)
    else $error("complete flag set while busy");
  a_pviol_set: assert property (@(posedge pclk) disable iff (!presetn) // see [R6]
    launch_prot |=> guard_violation_flag && !buf_full &&
      !($past(state) == NVMPS_IDLE && state == NVMPS_BUSY))
    else $error("protected command not rejected");
  a_mass_guard: assert property (@(posedge pclk) disable iff (!presetn) // see [R14]
    (launch && new_op == NVMPS_OP_MASS && gi.any && !launch_acc) |=> guard_violation_flag)
    else $error("mass erase allowed under protection");
  a_illegal_cmd: assert property (@(posedge pclk) disable iff (!presetn) // see [R12]
    (launch && new_op == NVMPS_OP_NONE) |=> sequence_error_flag && !buf_full &&
      !($past(state) == NVMPS_IDLE && state == NVMPS_BUSY))
    else $error("illegal command not flagged");
  a_pviol_hold: assert property (@(posedge pclk) disable iff (!presetn) // see [R7]
    (guard_violation_flag && !(wr && paddr == `NVMPS_OFF_STAT && pwdata[5])) |=>
      guard_violation_flag)
    else $error("violation flag cleared without write");
  a_accerr_hold: assert property (@(posedge pclk) disable iff (!presetn) // see [R9]
    (sequence_error_flag && !(wr && paddr == `NVMPS_OFF_STAT && pwdata[4])) |=>
      sequence_error_flag)
    else $error("access error flag cleared without write");
  a_blank_sec: assert property (@(posedge pclk) disable iff (!presetn) // see [R10] [R15]
    blank_pass |=> erased_verified_flag && security_state_code == 2'h2)
    else $error("blank pass not recorded");

  c_byte_prog: cover property (@(posedge pclk) disable iff (!presetn)
    launch_ok && new_op == NVMPS_OP_BYTE ##[1:40] cmd_complete_flag);
  c_burst_queue: cover property (@(posedge pclk) disable iff (!presetn)
    buf_full ##1 op_done);
  c_prot_viol: cover property (@(posedge pclk) disable iff (!presetn) launch_prot);
  c_blank_pass: cover property (@(posedge pclk) disable iff (!presetn) blank_pass);
endmodule : nvmps_top
